//--- pkg/smfm_pkg.sv
`default_nettype none
package smfm_pkg;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_ADDR   = 8'h08;
  localparam logic [7:0] OFS_SEGLIM = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_INTDST = 8'h14;
  localparam logic [7:0] OFS_VSEL   = 8'h18;
  localparam logic [7:0] OFS_VDATA  = 8'h1c;

  // Control register fields.
  localparam int CTL_FP_EMU     = 0;
  localparam int CTL_TASK_SW    = 1;
  localparam int CTL_EXT_STATE  = 2;
  localparam int CTL_VEC_FEAT   = 3;
  localparam int CTL_ALIGN_MASK = 4;
  localparam int CTL_FLAGS_AC   = 5;
  localparam int CTL_CPL_LO     = 6;
  localparam int CTL_MODE_LO    = 8;
  localparam int CTL_OS_NUM     = 10;
  localparam int CTL_DIS_FP     = 11;
  localparam int CTL_NAT_SRC    = 12;
  localparam int CTL_FPU_PEND   = 13;
  localparam int CTL_STACK_SEG  = 14;
  localparam int CTL_SEG16      = 15;
  localparam int CTL_NMASK_LO   = 16;
  localparam logic [31:0] CTRL_RESET   = 32'h001f000c;
  localparam logic [31:0] SEGLIM_RESET = 32'h0000ffff;
  localparam logic [32:0] REAL_LIMIT   = 33'h00000ffff;
  localparam logic [1:0]  CPL_USER     = 2'h3;

  // Command fields and status fields.
  localparam int CMD_DST_LO   = 4;
  localparam int CMD_SRC_LO   = 8;
  localparam int ST_BUSY      = 0;
  localparam int ST_DONE      = 1;
  localparam int ST_FAULT_LO  = 2;
  localparam int ST_MCODE_LO  = 6;
  localparam int ST_NUM_LO    = 10;

  typedef enum logic [1:0] {
    MODE_REAL   = 2'b00,
    MODE_PROT   = 2'b01,
    MODE_V86    = 2'b10,
    MODE_NATIVE = 2'b11
  } smfm_mode_t;

  typedef enum logic [3:0] {
    OP_LOW_LOAD  = 4'b0000,
    OP_LOW_STORE = 4'b0001,
    OP_MASK      = 4'b0010,
    OP_SS_LOAD   = 4'b0011,
    OP_SS_STORE  = 4'b0100,
    OP_SS_REG    = 4'b0101,
    OP_UP_LOAD   = 4'b0110,
    OP_UP_STORE  = 4'b0111,
    OP_UP_REG    = 4'b1000,
    OP_MUL_REG   = 4'b1001,
    OP_MUL_MEM   = 4'b1010
  } smfm_op_t;

  typedef enum logic [3:0] {
    FLT_NONE    = 4'h0,
    FLT_UD      = 4'h1,
    FLT_NM      = 4'h2,
    FLT_GP      = 4'h3,
    FLT_SS      = 4'h4,
    FLT_AC      = 4'h5,
    FLT_MF      = 4'h6,
    FLT_XM      = 4'h7,
    FLT_INT13   = 4'h8,
    FLT_PF      = 4'h9,
    FLT_DISFP   = 4'ha,
    FLT_NATREG  = 4'hb,
    FLT_MEMDATA = 4'hc
  } smfm_fault_t;

  // Data fault codes that the memory side returns in native mode.
  localparam logic [3:0] MF_HASHED_PT   = 4'h1;
  localparam logic [3:0] MF_TRANS_MISS  = 4'h2;
  localparam logic [3:0] MF_ALT_MISS    = 4'h3;
  localparam logic [3:0] MF_NOT_PRESENT = 4'h4;
  localparam logic [3:0] MF_NAT_PAGE    = 4'h5;
  localparam logic [3:0] MF_KEY_MISS    = 4'h6;
  localparam logic [3:0] MF_KEY_PERM    = 4'h7;
  localparam logic [3:0] MF_ACC_RIGHTS  = 4'h8;
  localparam logic [3:0] MF_ACC_BIT     = 4'h9;
  localparam logic [3:0] MF_DIRTY_BIT   = 4'ha;

  localparam logic [4:0] BYTES_WORD = 5'h04;
  localparam logic [4:0] BYTES_HALF = 5'h08;
  localparam logic [4:0] BYTES_FULL = 5'h10;

  typedef enum logic [1:0] {
    SM_IDLE  = 2'b00,
    SM_CHECK = 2'b01,
    SM_MEM   = 2'b10,
    SM_EXEC  = 2'b11
  } smfm_state_t;

  function automatic logic opIsStore(input smfm_op_t op);
    return op == OP_LOW_STORE || op == OP_SS_STORE || op == OP_UP_STORE;
  endfunction : opIsStore

  function automatic logic opIsMem(input smfm_op_t op);
    return op == OP_LOW_LOAD || op == OP_LOW_STORE || op == OP_SS_LOAD ||
           op == OP_SS_STORE || op == OP_UP_LOAD || op == OP_UP_STORE ||
           op == OP_MUL_MEM;
  endfunction : opIsMem

endpackage : smfm_pkg
`default_nettype wire

//--- pkg/smfm_core_if.sv
`default_nettype none
interface smfm_core_if;
  import smfm_pkg::*;
  logic [31:0]  ctrl;
  smfm_op_t     op;
  logic [31:0]  addr;
  logic [31:0]  segLim;
  smfm_fault_t  fault;
  logic [4:0]   accBytes;
  logic [127:0] mulA;
  logic [127:0] mulB;
  logic [127:0] mulRes;
  logic [4:0]   mulFlags;

  modport core (output ctrl, op, addr, segLim, mulA, mulB,
                input fault, accBytes, mulRes, mulFlags);
  modport chk  (input ctrl, op, addr, segLim, output fault, accBytes);
  modport mul  (input mulA, mulB, output mulRes, mulFlags);
endinterface : smfm_core_if
`default_nettype wire

//--- hw/smfm_fault_check.sv
`default_nettype none
module smfm_fault_check
  import smfm_pkg::*;
(
  // Checker side of the core interface
  smfm_core_if.chk ci
);

  logic       isMem;
  logic       moveMask;
  logic       unaligned;
  logic       acEnable;
  logic [32:0] lastByte;
  smfm_mode_t mode;
  logic [1:0] current_privilege_level;

  always_comb begin
    mode     = smfm_mode_t'(ci.ctrl[CTL_MODE_LO +: 2]);
    current_privilege_level      = ci.ctrl[CTL_CPL_LO +: 2];
    isMem    = opIsMem(ci.op);
    moveMask = ci.op != OP_MUL_REG && ci.op != OP_MUL_MEM;
    case (ci.op)
      OP_LOW_LOAD, OP_LOW_STORE: ci.accBytes = BYTES_HALF;
      OP_SS_LOAD, OP_SS_STORE:   ci.accBytes = BYTES_WORD;
      default:                   ci.accBytes = BYTES_FULL;
    endcase
    lastByte  = {1'b0, ci.addr} + {28'h0, ci.accBytes} - 33'h1;
    unaligned = (ci.addr[4:0] & (ci.accBytes - 5'h1)) != 5'h0;
    acEnable  = ci.ctrl[CTL_ALIGN_MASK] && ci.ctrl[CTL_FLAGS_AC] &&
                current_privilege_level == CPL_USER;
    ci.fault  = FLT_NONE;
    if (ci.ctrl[CTL_FP_EMU]) begin
      ci.fault = FLT_UD;
    end else if (moveMask && !ci.ctrl[CTL_EXT_STATE]) begin
      ci.fault = FLT_UD;
    end else if (moveMask && !ci.ctrl[CTL_VEC_FEAT]) begin
      ci.fault = FLT_UD;
    end else if (ci.ctrl[CTL_TASK_SW]) begin
      ci.fault = FLT_NM;
    end else if (mode == MODE_NATIVE && ci.ctrl[CTL_DIS_FP]) begin
      ci.fault = FLT_DISFP;
    end else if (mode == MODE_NATIVE && ci.ctrl[CTL_NAT_SRC]) begin
      ci.fault = FLT_NATREG;
    end else if (ci.op == OP_MASK && mode == MODE_PROT &&
                 ci.ctrl[CTL_FPU_PEND]) begin
      ci.fault = FLT_MF;
    end else if (isMem && mode != MODE_NATIVE) begin
      if (mode != MODE_PROT && lastByte > REAL_LIMIT) begin
        ci.fault = FLT_INT13;
      end else if (mode == MODE_PROT &&
                   lastByte > {1'b0, ci.segLim}) begin
        ci.fault = ci.ctrl[CTL_STACK_SEG] ? FLT_SS : FLT_GP;
      end else if (ci.op == OP_MUL_MEM && unaligned) begin
        ci.fault = FLT_GP;
      end else if (ci.op != OP_MUL_MEM && unaligned && acEnable) begin
        ci.fault = FLT_AC;
      end
    end else if (ci.op == OP_MUL_MEM && unaligned) begin
      ci.fault = FLT_GP;
    end
  end

endmodule : smfm_fault_check
`default_nettype wire

//--- hw/smfm_lane_mul.sv
`default_nettype none
module smfm_lane_mul
  import smfm_pkg::*;
#(
  parameter int LANES = 4
) (
  // Multiplier side of the core interface
  smfm_core_if.mul mi
);

  // Flags per lane: 4 invalid, 3 denormal, 2 overflow, 1 underflow, 0 inexact.
  logic [LANES-1:0][4:0] laneFlags;

  // per-lane multiply
  // Results truncate toward zero, except that overflow gives infinity; rounding modes are outside this block.
  for (genvar g = 0; g < LANES; g++) begin : gLane
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] r;
    logic [47:0] prod;
    logic [9:0]  expSum;
    logic        nanIn;
    logic        infIn;
    logic        zeroIn;
    logic        sign;
    logic [22:0] frac;
    logic        lost;
    always_comb begin
      a      = mi.mulA[32*g +: 32];
      b      = mi.mulB[32*g +: 32];
      sign   = a[31] ^ b[31];
      nanIn  = (&a[30:23] && |a[22:0]) || (&b[30:23] && |b[22:0]);
      infIn  = (&a[30:23] && a[22:0] == 23'h0) ||
               (&b[30:23] && b[22:0] == 23'h0);
      zeroIn = a[30:0] == 31'h0 || b[30:0] == 31'h0;
      prod   = {|a[30:23], a[22:0]} * {|b[30:23], b[22:0]};
      expSum = {2'b00, a[30:23]} + {2'b00, b[30:23]} - 10'h07f +
               {9'h0, prod[47]};
      frac   = prod[47] ? prod[46:24] : prod[45:23];
      lost   = prod[47] ? |prod[23:0] : |prod[22:0];
      laneFlags[g] = {nanIn || (infIn && zeroIn),
                      (a[30:23] == 8'h0 && |a[22:0]) ||
                      (b[30:23] == 8'h0 && |b[22:0]), 3'b000};
      if (nanIn || (infIn && zeroIn)) begin
        r = 32'h7fc00000;
      end else if (infIn) begin
        r = {sign, 8'hff, 23'h0};
      end else if (zeroIn || prod == 48'h0) begin
        r = {sign, 31'h0};
      end else if (!expSum[9] && expSum >= 10'h0ff) begin
        r = {sign, 8'hff, 23'h0};
        laneFlags[g][2] = 1'b1;
        laneFlags[g][0] = 1'b1;
      end else if (expSum[9] || expSum == 10'h000) begin
        r = {sign, 31'h0};
        laneFlags[g][1] = 1'b1;
        laneFlags[g][0] = 1'b1;
      end else begin
        r = {sign, expSum[7:0], frac};
        laneFlags[g][0] = lost;
      end
      mi.mulRes[32*g +: 32] = r;
    end
  end

  always_comb begin
    mi.mulFlags = 5'h0;
    for (int i = 0; i < LANES; i++) begin
      mi.mulFlags = mi.mulFlags | laneFlags[i];
    end
  end

endmodule : smfm_lane_mul
`default_nettype wire

//--- hw/simd_float_move_mask_unit.sv
`default_nettype none
module simd_float_move_mask_unit
  import smfm_pkg::*;
#(
  parameter int NREG = 8
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  // Memory subsystem
  output logic              memReq,
  output logic              memWrite,
  output logic [31:0]       memAddr,
  output logic [4:0]        memBytes,
  output logic [127:0]      memWdata,
  input  wire logic [127:0] memRdata,
  input  wire logic         memAck,
  input  wire logic [3:0]   memFault
);

  localparam int RW = $clog2(NREG);

  typedef struct packed {
    smfm_state_t              st;
    logic [31:0]              ctrl;
    smfm_op_t                 op;
    logic [RW-1:0]            dst;
    logic [RW-1:0]            src;
    logic [31:0]              addr;
    logic [31:0]              segLim;
    logic [31:0]              intDst;
    logic [RW+1:0]            vsel;
    logic                     wrPend;
    logic [7:0]               wrAddr;
    logic [31:0]              rdata;
    logic                     memReq;
    logic                     memWrite;
    logic [31:0]              memAddr;
    logic [4:0]               memBytes;
    logic [127:0]             memWdata;
    logic [127:0]             ldData;
    smfm_fault_t              fault;
    logic [3:0]               memCode;
    logic [4:0]               numFlags;
    logic                     done;
    logic [NREG-1:0][127:0]   vreg;
  } smfm_regs_t;

  smfm_regs_t state_r;
  smfm_regs_t state_nxt;

  smfm_core_if ci ();

  smfm_fault_check u_check (
    .ci (ci.chk)
  );

  smfm_lane_mul #(
    .LANES (4)
  ) u_mul (
    .mi (ci.mul)
  );

  function automatic logic [31:0] readReg(input smfm_regs_t s,
                                           input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      OFS_CTRL:   v = s.ctrl;
      OFS_CMD:    v = {20'h0, {(4-RW){1'b0}}, s.src,
                       {(4-RW){1'b0}}, s.dst, s.op};
      OFS_ADDR:   v = s.addr;
      OFS_SEGLIM: v = s.segLim;
      OFS_STATUS: v = {17'h0, s.numFlags, s.memCode, s.fault, s.done,
                       s.st != SM_IDLE};
      OFS_INTDST: v = s.intDst;
      OFS_VSEL:   v = {{(30-RW){1'b0}}, s.vsel};
      OFS_VDATA:  v = s.vreg[s.vsel[RW+1:2]][32*s.vsel[1:0] +: 32];
      default:    v = 32'h0;
    endcase
    return v;
  endfunction : readReg

  logic        addrPhase;
  logic        cmdWrite;
  logic        doneClr;
  logic        doneSet;
  logic [4:0]  unmasked;
  logic [31:0] wd;

  assign ci.ctrl   = state_r.ctrl;
  assign ci.op     = state_r.op;
  assign ci.addr   = state_r.addr;
  assign ci.segLim = state_r.segLim;
  assign ci.mulA   = state_r.vreg[state_r.dst];
  assign ci.mulB   = (state_r.op == OP_MUL_MEM) ? state_r.ldData
                                                : state_r.vreg[state_r.src];

  always_comb begin
    state_nxt = state_r;
    wd        = hwdata;
    addrPhase = hsel && htrans[1] && hready;
    cmdWrite  = state_r.wrPend && state_r.wrAddr == OFS_CMD &&
                state_r.st == SM_IDLE;
    doneClr   = state_r.wrPend && state_r.wrAddr == OFS_STATUS &&
                wd[ST_DONE];
    doneSet   = 1'b0;
    unmasked  = ci.mulFlags & ~state_r.ctrl[CTL_NMASK_LO +: 5];

    // Bus side: address phase captured, write data used one cycle later.
    // Reads are sampled at the address phase so hrdata comes from a flop.
    state_nxt.wrPend = addrPhase && hwrite && haddr[31:8] == 24'h0 &&
                       haddr[1:0] == 2'b00;
    if (addrPhase) begin
      state_nxt.wrAddr = haddr[7:0];
      state_nxt.rdata  = (haddr[31:8] == 24'h0 && haddr[1:0] == 2'b00)
                         ? readReg(state_r, haddr[7:0]) : 32'h0;
    end
    if (state_r.wrPend) begin
      case (state_r.wrAddr)
        OFS_CTRL:   state_nxt.ctrl   = wd;
        OFS_ADDR:   state_nxt.addr   = wd;
        OFS_SEGLIM: state_nxt.segLim = wd;
        OFS_VSEL:   state_nxt.vsel   = wd[RW+1:0];
        OFS_VDATA: begin
          if (state_r.st == SM_IDLE) begin
            state_nxt.vreg[state_r.vsel[RW+1:2]]
                          [32*state_r.vsel[1:0] +: 32] = wd;
          end
        end
        default: ;
      endcase
    end

    case (state_r.st)
      SM_IDLE: begin
        if (cmdWrite) begin
          state_nxt.op       = smfm_op_t'(wd[3:0]);
          state_nxt.dst      = wd[CMD_DST_LO +: RW];
          state_nxt.src      = wd[CMD_SRC_LO +: RW];
          state_nxt.fault    = FLT_NONE;
          state_nxt.memCode  = 4'h0;
          state_nxt.numFlags = 5'h0;
          state_nxt.st       = SM_CHECK;
        end
      end
      SM_CHECK: begin
        if (ci.fault != FLT_NONE) begin
          state_nxt.fault = ci.fault;
          doneSet         = 1'b1;
          state_nxt.st    = SM_IDLE;
        end else if (opIsMem(state_r.op)) begin
          state_nxt.memReq   = 1'b1;
          state_nxt.memAddr  = state_r.addr;
          state_nxt.memBytes = ci.accBytes;
          state_nxt.memWrite = opIsStore(state_r.op);
          case (state_r.op)
            OP_LOW_STORE:
              state_nxt.memWdata = {64'h0, state_r.vreg[state_r.src][63:0]};
            OP_SS_STORE:
              state_nxt.memWdata = {96'h0, state_r.vreg[state_r.src][31:0]};
            default:
              state_nxt.memWdata = state_r.vreg[state_r.src];
          endcase
          state_nxt.st = SM_MEM;
        end else begin
          state_nxt.st = SM_EXEC;
        end
      end
      SM_MEM: begin
        if (memAck) begin
          state_nxt.memReq = 1'b0;
          if (memFault != 4'h0) begin
            state_nxt.fault = (state_r.ctrl[CTL_MODE_LO +: 2] == MODE_NATIVE)
                              ? FLT_MEMDATA : FLT_PF;
            state_nxt.memCode = memFault;
            doneSet           = 1'b1;
            state_nxt.st      = SM_IDLE;
          end else if (state_r.memWrite) begin
            doneSet      = 1'b1;
            state_nxt.st = SM_IDLE;
          end else begin
            state_nxt.ldData = memRdata;
            state_nxt.st     = SM_EXEC;
          end
        end
      end
      SM_EXEC: begin
        doneSet      = 1'b1;
        state_nxt.st = SM_IDLE;
        case (state_r.op)
          OP_LOW_LOAD:
            state_nxt.vreg[state_r.dst][63:0] = state_r.ldData[63:0];
          OP_MASK:
            state_nxt.intDst = {28'h0000000,
                                state_r.vreg[state_r.src][127],
                                state_r.vreg[state_r.src][95],
                                state_r.vreg[state_r.src][63],
                                state_r.vreg[state_r.src][31]};
          OP_SS_LOAD:
            state_nxt.vreg[state_r.dst] = {96'h0, state_r.ldData[31:0]};
          OP_SS_REG:
            state_nxt.vreg[state_r.dst][31:0] =
              state_r.vreg[state_r.src][31:0];
          OP_UP_LOAD:
            state_nxt.vreg[state_r.dst] = state_r.ldData;
          OP_UP_REG:
            state_nxt.vreg[state_r.dst] = state_r.vreg[state_r.src];
          OP_MUL_REG, OP_MUL_MEM: begin
            state_nxt.numFlags = ci.mulFlags;
            if (unmasked != 5'h0) begin
              state_nxt.fault = state_r.ctrl[CTL_OS_NUM] ? FLT_XM : FLT_UD;
            end else begin
              state_nxt.vreg[state_r.dst] = ci.mulRes;
            end
          end
          default: state_nxt.fault = FLT_UD;
        endcase
      end
      default: state_nxt.st = SM_IDLE;
    endcase

    // Completion wins over a software clear in the same cycle.
    state_nxt.done = doneSet || (state_r.done && !doneClr);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r        <= '0;
      state_r.st     <= SM_IDLE;
      state_r.ctrl   <= CTRL_RESET;
      state_r.segLim <= SEGLIM_RESET;
      state_r.fault  <= FLT_NONE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Zero wait states; every transfer, mapped or not, answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = state_r.rdata;
  assign memReq    = state_r.memReq;
  assign memWrite  = state_r.memWrite;
  assign memAddr   = state_r.memAddr;
  assign memBytes  = state_r.memBytes;
  assign memWdata  = state_r.memWdata;

endmodule : simd_float_move_mask_unit
`default_nettype wire

//--- bench/smfm_properties.sv
`default_nettype none
module smfm_properties
  import smfm_pkg::*;
(
  // Clock, reset and bus
  input wire logic         sys_clk,
  input wire logic         rst_b,
  input wire logic         hsel,
  input wire logic         hready,
  input wire logic [31:0]  haddr,
  input wire logic [1:0]   htrans,
  input wire logic         hwrite,
  input wire logic [31:0]  hwdata,
  // Memory side
  input wire logic         memReq,
  input wire logic         memWrite,
  input wire logic [31:0]  memAddr,
  input wire logic [4:0]   memBytes,
  input wire logic [127:0] memWdata,
  input wire logic         memAck
);
  timeunit 1ns;
  timeprecision 1ps;
  // The control word is mirrored here because no port shows it.
  logic [31:0] ctrl_r;
  logic        ctrlWr_r;
  wire logic [1:0] mode = ctrl_r[9:8];
  wire logic acOn = ctrl_r[CTL_ALIGN_MASK] && ctrl_r[CTL_FLAGS_AC] &&
                    ctrl_r[7:6] == CPL_USER && mode != MODE_NATIVE;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r   <= CTRL_RESET;
      ctrlWr_r <= 1'b0;
    end else begin
      ctrlWr_r <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0;
      if (ctrlWr_r) ctrl_r <= hwdata;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  size_legal_a: assert property (memReq |-> memBytes == BYTES_WORD ||
    memBytes == BYTES_HALF || memBytes == BYTES_FULL)
    else $error("illegal byte count");
  req_hold_a: assert property (memReq && !memAck |=> memReq &&
    $stable(memAddr) && $stable(memBytes) && $stable(memWrite))
    else $error("request changed before acknowledge");
  req_end_a: assert property (memReq && memAck |=> !memReq)
    else $error("request outlived acknowledge");
  word_store_a: assert property (memReq && memWrite &&
    memBytes == BYTES_WORD |-> memWdata[127:32] == 96'h0)
    else $error("scalar store drives upper bytes");
  unit_off_a: assert property ($rose(memReq) |->
    !ctrl_r[CTL_FP_EMU] && !ctrl_r[CTL_TASK_SW])
    else $error("access while unit disabled");
  feature_gate_a: assert property ($rose(memReq) &&
    memBytes != BYTES_FULL |-> ctrl_r[CTL_EXT_STATE] && ctrl_r[CTL_VEC_FEAT])
    else $error("access without feature support");
  real_limit_a: assert property ($rose(memReq) && mode == MODE_REAL |->
    {1'b0, memAddr} + {28'h0, memBytes} - 33'h1 <= REAL_LIMIT)
    else $error("real mode access past limit");
  align_chk_a: assert property ($rose(memReq) && acOn &&
    memBytes != BYTES_FULL |-> (memAddr[2:0] & (memBytes[2:0] - 3'h1)) == 3'h0)
    else $error("unaligned access not refused");
endmodule : smfm_properties

bind simd_float_move_mask_unit smfm_properties props (.sys_clk, .rst_b,
  .hsel, .hready, .haddr, .htrans, .hwrite, .hwdata, .memReq, .memWrite,
  .memAddr, .memBytes, .memWdata, .memAck);
`default_nettype wire

//--- bench/smfm_mem_model.sv
`default_nettype none
module smfm_mem_model (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // Request side
  input  wire logic         memReq,
  input  wire logic         memWrite,
  input  wire logic [31:0]  memAddr,
  input  wire logic [127:0] memWdata,
  // Answer delay and fault code set by the bench
  input  wire logic [3:0]   lat,
  input  wire logic [3:0]   fcode,
  // Answer side
  output logic [127:0]      memRdata,
  output logic [127:0]      lastW,
  output logic              memAck,
  output logic [3:0]        memFault
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt      <= 4'h0;
      memAck   <= 1'b0;
      memRdata <= '0;
      lastW    <= '0;
      memFault <= 4'h0;
    end else if (memReq && !memAck && cnt == lat) begin
      memAck   <= 1'b1;
      memFault <= fcode;
      memRdata <= {memAddr + 32'hc, memAddr + 32'h8, memAddr + 32'h4, memAddr};
      if (memWrite && fcode == 4'h0) lastW <= memWdata;
      cnt      <= 4'h0;
    end else begin
      // Off the answer the lines toggle, so stale data cannot pass.
      memAck   <= 1'b0;
      memRdata <= ~memRdata;
      memFault <= ~memFault;
      cnt      <= (memReq && !memAck) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : smfm_mem_model
`default_nettype wire

//--- bench/tb.sv
`default_nettype none
module tb
  import smfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] c;
    logic [15:0] a;
    logic [3:0]  op;
    logic [3:0]  fc;
    logic [3:0]  f;
  } smfm_row_t;
  localparam logic [31:0] RB = 32'h001f000c;
  localparam logic [31:0] PB = 32'h001f010c;
  logic              sys_clk, rst_b, hwrite;
  logic [1:0]        htrans;
  logic [31:0]       haddr, hwdata, rd, st;
  logic [3:0]        lat, fc;
  logic [127:0]      v, r;
  wire logic         hready, hresp, memReq, memWrite, memAck;
  wire logic [31:0]  hrdata, memAddr;
  wire logic [4:0]   memBytes;
  wire logic [3:0]   memFault;
  wire logic [127:0] memWdata, memRdata, lastW;
  int                err_total, num_checks;
  smfm_row_t rows [18] = '{
    '{RB | 32'h1, 16'h0, OP_SS_LOAD, 4'h0, FLT_UD},
    '{RB | 32'h3, 16'h0, OP_SS_LOAD, 4'h0, FLT_UD},
    '{RB | 32'h2, 16'h0, OP_MASK, 4'h0, FLT_NM},
    '{32'h001f0108, 16'h0, OP_MASK, 4'h0, FLT_UD},
    '{32'h001f0104, 16'h0, OP_UP_REG, 4'h0, FLT_UD},
    '{RB, 16'hfffd, OP_SS_LOAD, 4'h0, FLT_INT13},
    '{RB, 16'hfffc, OP_SS_LOAD, 4'h0, FLT_NONE},
    '{32'h001f210c, 16'h0, OP_MASK, 4'h0, FLT_MF},
    '{PB, 16'hfff1, OP_UP_LOAD, 4'h0, FLT_GP},
    '{32'h001f410c, 16'hfff1, OP_UP_LOAD, 4'h0, FLT_SS},
    '{PB, 16'h0104, OP_MUL_MEM, 4'h0, FLT_GP},
    '{32'h001f01fc, 16'h0101, OP_SS_LOAD, 4'h0, FLT_AC},
    '{32'h001f013c, 16'h0101, OP_SS_LOAD, 4'h0, 4'h0},
    '{32'h001f01fc, 16'h0104, OP_SS_LOAD, 4'h0, 4'h0},
    '{32'h001f02fc, 16'h0101, OP_UP_STORE, 4'h0, FLT_AC},
    '{32'h001f020c, 16'h0100, OP_LOW_LOAD, 4'h5, FLT_PF},
    '{32'h001f0b0c, 16'h0, OP_SS_REG, 4'h0, FLT_DISFP},
    '{32'h001f130c, 16'h0, OP_MASK, 4'h0, FLT_NATREG}
  };
  simd_float_move_mask_unit uut (.sys_clk, .rst_b, .hsel(1'b1), .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hreadyout(hready), .hresp, .hrdata, .memReq, .memWrite, .memAddr,
    .memBytes, .memWdata, .memRdata, .memAck, .memFault);
  smfm_mem_model mem (.sys_clk, .rst_b, .memReq, .memWrite, .memAddr,
    .memWdata, .lat, .fcode(fc), .memRdata, .lastW, .memAck, .memFault);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [127:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic setv(input logic [2:0] n, input logic [127:0] x);
    for (int i = 0; i < 4; i++) begin
      bus(OFS_VSEL, 1'b1, {27'h0, n, i[1:0]});
      bus(OFS_VDATA, 1'b1, x[32*i +: 32]);
    end
  endtask : setv
  task automatic getv(input logic [2:0] n);
    for (int i = 0; i < 4; i++) begin
      bus(OFS_VSEL, 1'b1, {27'h0, n, i[1:0]});
      bus(OFS_VDATA, 1'b0, 32'h0);
      r[32*i +: 32] = rd;
    end
  endtask : getv
  function automatic logic [31:0] cmd(input logic [2:0] d, s,
                                      input logic [3:0] o);
    return {21'h0, s, 1'b0, d, o};
  endfunction : cmd
  task automatic run(input logic [31:0] c, a, k);
    bus(OFS_CTRL, 1'b1, c);
    bus(OFS_ADDR, 1'b1, a);
    bus(OFS_CMD, 1'b1, k);
    st = 32'h0;
    for (int n = 0; n < 40 && st[ST_DONE] !== 1'b1; n++) begin
      bus(OFS_STATUS, 1'b0, 32'h0);
      st = rd;
    end
    bus(OFS_STATUS, 1'b1, 32'h2);
  endtask : run
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    #(25 * 20000);
    err_total++;
    print_verdict();
  end
  initial begin
    {rst_b, hwrite, htrans, haddr, hwdata, lat, fc} = '0;
    err_total = 0;
    num_checks = 0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    bus(OFS_CTRL, 1'b0, 32'h0);
    chk(rd, CTRL_RESET);
    bus(OFS_SEGLIM, 1'b0, 32'h0);
    chk(rd, SEGLIM_RESET);
    bus(8'h20, 1'b1, 32'hffffffff);
    bus(8'h20, 1'b0, 32'h0);
    chk(rd, 32'h0);
    foreach (rows[i]) begin
      fc <= rows[i].fc;
      run(rows[i].c, {16'h0, rows[i].a}, cmd(3'h0, 3'h0, rows[i].op));
      chk({st[ST_DONE], st[5:2]}, {1'b1, rows[i].f});
    end
    for (int k = 1; k <= 10; k++) begin
      fc <= 4'(k);
      run(32'h001f030c, 32'h300, cmd(3'h0, 3'h0, OP_SS_LOAD));
      chk(st[9:2], {4'(k), FLT_MEMDATA});
    end
    fc <= 4'h0;
    // Slow memory answers from here on.
    lat <= 4'h5;
    v = {32'h80000001, 32'h7fffffff, 32'hc0000000, 32'h00000005};
    setv(3'h1, v);
    setv(3'h2, {4{32'h12345678}});
    run(PB, 32'h0, cmd(3'h0, 3'h1, OP_MASK));
    bus(OFS_INTDST, 1'b0, 32'h0);
    chk(rd, 32'ha);
    run(PB, 32'h0, cmd(3'h2, 3'h1, OP_SS_REG));
    getv(3'h2);
    chk(r, {{3{32'h12345678}}, v[31:0]});
    run(PB, 32'h100, cmd(3'h2, 3'h0, OP_SS_LOAD));
    getv(3'h2);
    chk(r, {96'h0, 32'h100});
    run(RB, 32'hfffd, cmd(3'h2, 3'h0, OP_SS_LOAD));
    getv(3'h2);
    chk(r, {96'h0, 32'h100});
    run(PB, 32'h400, cmd(3'h2, 3'h0, OP_LOW_LOAD));
    getv(3'h2);
    chk(r, {64'h0, 32'h404, 32'h400});
    run(PB, 32'h2009, cmd(3'h0, 3'h1, OP_LOW_STORE));
    chk(lastW, {64'h0, v[63:0]});
    run(PB, 32'h1003, cmd(3'h3, 3'h0, OP_UP_LOAD));
    chk(st[5:2], FLT_NONE);
    getv(3'h3);
    chk(r, {32'h100f, 32'h100b, 32'h1007, 32'h1003});
    run(PB, 32'h2001, cmd(3'h0, 3'h1, OP_UP_STORE));
    chk(lastW, v);
    run(PB, 32'h2005, cmd(3'h0, 3'h1, OP_SS_STORE));
    chk(lastW, {96'h0, v[31:0]});
    run(PB, 32'h0, cmd(3'h4, 3'h1, OP_UP_REG));
    getv(3'h4);
    chk(r, v);
    setv(3'h5, {4{32'h3fc00000}});
    setv(3'h6, {4{32'h40000000}});
    run(PB, 32'h0, cmd(3'h5, 3'h6, OP_MUL_REG));
    getv(3'h5);
    chk(r, {4{32'h40400000}});
    setv(3'h5, {4{32'h7f000000}});
    run(32'h001b050c, 32'h0, cmd(3'h5, 3'h6, OP_MUL_REG));
    chk(st[5:2], FLT_XM);
    run(32'h001b010c, 32'h0, cmd(3'h5, 3'h6, OP_MUL_REG));
    chk(st[5:2], FLT_UD);
    getv(3'h5);
    chk(r, {4{32'h7f000000}});
    run(PB, 32'h0, cmd(3'h5, 3'h6, OP_MUL_REG));
    chk({st[12], st[5:2]}, {1'b1, FLT_NONE});
    run(32'h001f030c, 32'h3f800000, cmd(3'h6, 3'h0, OP_MUL_MEM));
    getv(3'h6);
    chk(r, {32'h4000000c, 32'h40000008, 32'h40000004, 32'h40000000});
    print_verdict();
  end
endmodule : tb
`default_nettype wire
